// [design/ali_pkg.sv]
/*
 * Constants, types and register map of the front-panel lamp controller.
 * Assumes one 200 MHz clock, a synchronous active-high reset and an
 * Avalon-MM master with 32-bit data and byte addresses.
 */
// Contract
// - Blue lamp steady on with management power while extraction is safe.
// - Blue lamp dark while the module is operational.
// - Blue lamp flashes long blink while waiting for activation.
// - Blue lamp flashes short blink while waiting for deactivation.
// - Red lamp on for shelf fault flag or missing 12V payload power.
// - Green lamp steady with 12V present and no disk activity.
// - Green lamp blinks on disk activity.
// - Green lamp dark without 12V payload power.
// - Blue lamp switches on as soon as the module is fully inserted.
// - Blue lamp switches off when activation completes.
// - Opening the handle blinks blue, then steady; extract only when steady.
package ali_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 200;
    localparam int TICK_US        = 1000;
    localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
    localparam int LONG_HALF_MS   = 500;
    localparam int SHORT_HALF_MS  = 100;
    localparam int ACT_HALF_MS    = 50;
    localparam int ACT_STRETCH_MS = 100;
    localparam int MS_W           = 10;
    localparam int TICK_W         = 18;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam int CTRL_FAULT_BIT     = 0;
    localparam int CTRL_ACT_GO_BIT    = 1;
    localparam int CTRL_DEACT_GO_BIT  = 2;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ABSENT     = 3'h0,
        ST_SAFE       = 3'h1,
        ST_ACT_WAIT   = 3'h2,
        ST_ACTIVE     = 3'h3,
        ST_DEACT_WAIT = 3'h4
    } ali_swap_e;

    typedef struct packed {
        logic mgmt_power_ok;
        logic inserted;
        logic handle_closed;
        logic payload_12v_ok;
        logic disk_activity;
    } ali_in_s;

    typedef struct packed {
        logic hot_swap_lamp;
        logic fault_out_of_service_lamp;
        logic module_active_lamp;
    } ali_lamp_s;

endpackage : ali_pkg

// [design/ali_led_ctrl.sv]
/*
 * Front-panel lamp controller: hot-swap, fault and activity lamps.
 * Assumes board inputs synchronous to clk_sys and a single Avalon-MM
 * master that holds each request until waitrequest is low.
 */
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps

module ali_led_ctrl #(
    parameter int unsigned TICK_CYCLES    = ali_pkg::TICK_CYCLES,
    parameter logic [9:0]  LONG_HALF_MS   = 10'(ali_pkg::LONG_HALF_MS),
    parameter logic [9:0]  SHORT_HALF_MS  = 10'(ali_pkg::SHORT_HALF_MS),
    parameter logic [9:0]  ACT_HALF_MS    = 10'(ali_pkg::ACT_HALF_MS),
    parameter logic [9:0]  ACT_STRETCH_MS = 10'(ali_pkg::ACT_STRETCH_MS)
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              srst,
    // Avalon-MM slave
    input  wire logic [3:0]        address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [3:0]        byteenable,
    input  wire logic [31:0]       writedata,
    output logic [31:0]            readdata,
    output logic [1:0]             response,
    output logic                   waitrequest,
    // Board state
    input  wire ali_pkg::ali_in_s  board_in,
    // Lamps
    output ali_pkg::ali_lamp_s     lamps
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [ali_pkg::TICK_W-1:0] tick_cnt_q;
    logic                       tick_ms;
    logic [2:0]                 phase;
    logic [9:0]                 half_ms [3];
    logic                       fault_flag_q;
    logic                       act_go;
    logic                       deact_go;
    logic                       ack_q;
    logic                       req;
    logic                       hit_ctrl;
    logic                       hit_status;
    logic [31:0]                readdata_q;
    logic [1:0]                 response_q;
    logic [9:0]                 stretch_q;
    logic                       busy;
    ali_pkg::ali_swap_e         state_q;
    ali_pkg::ali_swap_e         state_d;
    ali_pkg::ali_lamp_s         lamps_q;
    ali_pkg::ali_lamp_s         lamps_d;

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tick_cnt_q <= '0;
        end else if (tick_ms) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    assign tick_ms = (tick_cnt_q == ali_pkg::TICK_W'(TICK_CYCLES - 1));

    // ------------------------------------------------------------
    // Blink generators: 0 long, 1 short, 2 activity
    // ------------------------------------------------------------
    assign half_ms[0] = LONG_HALF_MS;
    assign half_ms[1] = SHORT_HALF_MS;
    assign half_ms[2] = ACT_HALF_MS;

    for (genvar g = 0; g < 3; g++) begin : g_blink
        logic [9:0] cnt_q;
        logic       ph_q;
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                cnt_q <= '0;
                ph_q  <= 1'b1;
            end else if (tick_ms) begin
                if (cnt_q >= half_ms[g] - 10'h001) begin
                    cnt_q <= '0;
                    ph_q  <= ~ph_q;
                end else begin
                    cnt_q <= cnt_q + 10'h001;
                end
            end
        end
        assign phase[g] = ph_q;
    end

    // ------------------------------------------------------------
    // Disk activity stretch
    // ------------------------------------------------------------
    // Short activity pulses are held long enough to be seen
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stretch_q <= '0;
        end else if (board_in.disk_activity) begin
            stretch_q <= ACT_STRETCH_MS;
        end else if (tick_ms && stretch_q != 10'h000) begin
            stretch_q <= stretch_q - 10'h001;
        end
    end

    assign busy = board_in.disk_activity || (stretch_q != 10'h000);

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    assign req        = read || write;
    assign hit_ctrl   = (address == ali_pkg::OFS_CTRL);
    assign hit_status = (address == ali_pkg::OFS_STATUS);

    // One wait cycle, then the answer on the second edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    assign waitrequest = req && !ack_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            readdata_q <= '0;
            response_q <= ali_pkg::RESP_OKAY;
        end else if (req && !ack_q) begin
            response_q <= (hit_ctrl || hit_status) ? ali_pkg::RESP_OKAY
                                                   : ali_pkg::RESP_SLVERR;
            readdata_q <= '0;
            if (read && hit_ctrl) begin
                readdata_q[ali_pkg::CTRL_FAULT_BIT] <= fault_flag_q;
            end else if (read && hit_status) begin
                readdata_q[2:0] <= state_q;
                readdata_q[3]   <= lamps_q.hot_swap_lamp;
                readdata_q[4]   <= lamps_q.fault_out_of_service_lamp;
                readdata_q[5]   <= lamps_q.module_active_lamp;
                readdata_q[6]   <= board_in.payload_12v_ok;
                readdata_q[7]   <= board_in.inserted;
                readdata_q[8]   <= board_in.handle_closed;
                readdata_q[9]   <= board_in.mgmt_power_ok;
                readdata_q[10]  <= busy;
            end
        end
    end

    assign readdata = readdata_q;
    assign response = response_q;

    // Control writes take effect at the edge where waitrequest is low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fault_flag_q <= 1'b0;
        end else if (write && ack_q && hit_ctrl && byteenable[0]) begin
            fault_flag_q <= writedata[ali_pkg::CTRL_FAULT_BIT];
        end
    end

    assign act_go   = write && ack_q && hit_ctrl && byteenable[0]
                      && writedata[ali_pkg::CTRL_ACT_GO_BIT];
    assign deact_go = write && ack_q && hit_ctrl && byteenable[0]
                      && writedata[ali_pkg::CTRL_DEACT_GO_BIT];

    // ------------------------------------------------------------
    // Hot-swap sequence
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ali_pkg::ST_ABSENT: begin
                if (board_in.inserted && board_in.mgmt_power_ok) begin
                    state_d = ali_pkg::ST_SAFE;
                end
            end
            ali_pkg::ST_SAFE: begin
                if (board_in.handle_closed) begin
                    state_d = ali_pkg::ST_ACT_WAIT;
                end
            end
            ali_pkg::ST_ACT_WAIT: begin
                if (!board_in.handle_closed) begin
                    state_d = ali_pkg::ST_SAFE;
                end else if (act_go) begin
                    state_d = ali_pkg::ST_ACTIVE;
                end
            end
            ali_pkg::ST_ACTIVE: begin
                if (!board_in.handle_closed) begin
                    state_d = ali_pkg::ST_DEACT_WAIT;
                end
            end
            ali_pkg::ST_DEACT_WAIT: begin
                if (deact_go) begin
                    state_d = ali_pkg::ST_SAFE;
                end
            end
            default: begin
                state_d = ali_pkg::ST_ABSENT;
            end
        endcase
        if (!board_in.inserted || !board_in.mgmt_power_ok) begin
            state_d = ali_pkg::ST_ABSENT;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ali_pkg::ST_ABSENT;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Lamp drive
    // ------------------------------------------------------------
    always_comb begin
        lamps_d = '0;
        unique case (state_d)
            ali_pkg::ST_SAFE:       lamps_d.hot_swap_lamp = 1'b1;
            ali_pkg::ST_ACT_WAIT:   lamps_d.hot_swap_lamp = phase[0];
            ali_pkg::ST_ACTIVE:     lamps_d.hot_swap_lamp = 1'b0;
            ali_pkg::ST_DEACT_WAIT: lamps_d.hot_swap_lamp = phase[1];
            default:                lamps_d.hot_swap_lamp = 1'b0;
        endcase
        lamps_d.fault_out_of_service_lamp =
            fault_flag_q || !board_in.payload_12v_ok;
        if (!board_in.payload_12v_ok) begin
            lamps_d.module_active_lamp = 1'b0;
        end else if (busy) begin
            lamps_d.module_active_lamp = phase[2];
        end else begin
            lamps_d.module_active_lamp = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lamps_q <= '0;
        end else begin
            lamps_q <= lamps_d;
        end
    end

    assign lamps = lamps_q;

endmodule : ali_led_ctrl

// [dv/ali_chk.sv]
/*
 * Port checker of the lamp controller.
 * Assumes the bind below and a design clocked by clk_sys.
 */
`timescale 1ns/1ps

module ali_chk #(
    parameter int unsigned TICK_CYCLES    = 4,
    parameter logic [9:0]  ACT_STRETCH_MS = 10'h3
) (
    // Clock and bus
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic [3:0]        address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [3:0]        byteenable,
    input wire logic [31:0]       writedata,
    input wire logic [1:0]        response,
    input wire logic              waitrequest,
    // Board and lamps
    input wire ali_pkg::ali_in_s  board_in,
    input wire ali_pkg::ali_lamp_s lamps
);
    localparam int QUIET = (int'(ACT_STRETCH_MS) + 2) * int'(TICK_CYCLES) + 4;
    logic [15:0] quiet_q;
    logic        rst_q;

    // Attempts started at the release edge would still see reset lamps
    always_ff @(posedge clk_sys) begin
        rst_q <= srst;
    end

    // Cycles with payload power and no disk activity
    always_ff @(posedge clk_sys) begin
        if (srst || !board_in.payload_12v_ok || board_in.disk_activity) begin
            quiet_q <= 16'h0;
        end else if (quiet_q != 16'hffff) begin
            quiet_q <= quiet_q + 16'h1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst || rst_q);

    red_nopwr_a: assert property (
        !board_in.payload_12v_ok |=> lamps.fault_out_of_service_lamp)
        else $error("red lamp dark without payload power");
    fault_set_a: assert property (
        write && !waitrequest && address == ali_pkg::OFS_CTRL && byteenable[0]
        && writedata[0] |-> ##[1:2] lamps.fault_out_of_service_lamp)
        else $error("red lamp dark after fault flag write");
    bus_slverr_a: assert property (
        (read || write) && !waitrequest && !(address inside {4'h0, 4'h4})
        |-> response == ali_pkg::RESP_SLVERR)
        else $error("unmapped access not refused");
    one_wait_a: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    green_dark_a: assert property (
        !board_in.payload_12v_ok |=> !lamps.module_active_lamp)
        else $error("green lamp lit without payload power");
    green_steady_a: assert property (
        quiet_q >= 16'(QUIET) |-> lamps.module_active_lamp)
        else $error("green lamp not steady when idle");
    green_blink_a: assert property (
        $rose(board_in.disk_activity) && board_in.payload_12v_ok
        |-> ##[1:12] !lamps.module_active_lamp)
        else $error("green lamp does not blink on activity");
    blue_absent_a: assert property (
        !board_in.mgmt_power_ok |=> !lamps.hot_swap_lamp)
        else $error("blue lamp lit without management power");
    blue_insert_a: assert property (
        $rose(board_in.inserted) && board_in.mgmt_power_ok |=> lamps.hot_swap_lamp)
        else $error("blue lamp dark after insertion");
endmodule : ali_chk

bind ali_led_ctrl ali_chk #(.TICK_CYCLES(TICK_CYCLES), .ACT_STRETCH_MS(ACT_STRETCH_MS)) u_chk (
    .clk_sys(clk_sys), .srst(srst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .response(response),
    .waitrequest(waitrequest), .board_in(board_in), .lamps(lamps));

// [dv/ali_board_mdl.sv]
/*
 * Board side: management controller, handle and power detect.
 * Assumes the bench sets the wanted board state at rising edges.
 */
`timescale 1ns/1ps

module ali_board_mdl #(
    parameter int STEADY = 40
) (
    // Clock and wanted state
    input wire logic             clk_sys,
    input wire ali_pkg::ali_in_s want,
    input wire logic             blue,
    // Board inputs of the controller
    output ali_pkg::ali_in_s     board_in
);
    logic [7:0]       lit_q = 8'h0;
    ali_pkg::ali_in_s nxt;

    always_ff @(posedge clk_sys) begin
        lit_q <= blue ? ((lit_q == 8'hff) ? lit_q : lit_q + 8'h1) : 8'h0;
    end

    // Card is pulled only once the blue lamp has stayed steady
    always_comb begin
        nxt = want;
        if (board_in.inserted && !want.inserted && lit_q < 8'(STEADY)) begin
            nxt.inserted = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        board_in <= nxt;
    end
endmodule : ali_board_mdl

// [dv/tb.sv]
/*
 * Self-checking bench of the lamp controller.
 * Assumes the board model and checker of this folder.
 */
`timescale 1ns/1ps

module tb;
    localparam int TK = 4;
    logic              clk_sys = 1'b0;
    logic              srst = 1'b1;
    logic [3:0]        address = 4'h0;
    logic              read = 1'b0;
    logic              write = 1'b0;
    logic [3:0]        byteenable = 4'hf;
    logic [31:0]       writedata = 32'h0;
    logic [31:0]       readdata, q, d;
    logic [1:0]        response, r;
    logic              waitrequest, ef, pg;
    ali_pkg::ali_in_s  want = '0;
    ali_pkg::ali_in_s  board_in;
    ali_pkg::ali_lamp_s lamps;
    int                mismatches = 0;
    int                compares = 0;
    int                tog;

    always #2.5 clk_sys = ~clk_sys;

    ali_led_ctrl #(.TICK_CYCLES(TK), .LONG_HALF_MS(10'h4), .SHORT_HALF_MS(10'h2),
        .ACT_HALF_MS(10'h1), .ACT_STRETCH_MS(10'h3)) uut (.clk_sys(clk_sys), .srst(srst),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .response(response),
        .waitrequest(waitrequest), .board_in(board_in), .lamps(lamps));
    ali_board_mdl u_mdl (.clk_sys(clk_sys), .want(want), .blue(lamps.hot_swap_lamp),
        .board_in(board_in));

    function automatic logic [31:0] half(input logic [9:0] ms);
        return 32'(ms) * 32'(TK);
    endfunction : half
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be,
                       input logic [31:0] wd);
        address <= a; byteenable <= be; writedata <= wd; read <= !wr; write <= wr;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        q = readdata; r = response;
        read <= 1'b0; write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic per(input logic [31:0] exp);
        int n;
        logic b;
        for (int k = 0; k < 2; k++) begin
            b = lamps.hot_swap_lamp; n = 0;
            while (lamps.hot_swap_lamp === b && n < 200) begin @(posedge clk_sys); n++; end
        end
        chk(32'(n), exp);
    endtask : per
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    initial begin
        #50us; mismatches++; test_done();
    end

    initial begin
        void'($urandom(32'hd5ca));
        cyc(20); srst <= 1'b0; cyc(3);
        chk(32'(lamps), 32'h2);
        want <= ali_pkg::ali_in_s'(5'h1a); cyc(3);
        chk(32'(lamps), 32'h5);
        bus(1'b0, 4'h4, 4'hf, 32'h0); chk(q, 32'h2e9);
        chk(32'(r), 32'(ali_pkg::RESP_OKAY));
        bus(1'b0, 4'h8, 4'hf, 32'h0); chk(q, 32'h0);
        chk(32'(r), 32'(ali_pkg::RESP_SLVERR));
        want.handle_closed <= 1'b1;
        per(half(10'h4));
        bus(1'b1, 4'h0, 4'h1, 32'h2); cyc(2); chk(32'(lamps), 32'h1);
        ef = 1'b0;
        repeat (8) begin
            d = $urandom; pg = 1'($urandom);
            bus(1'b1, 4'h0, {3'h0, pg}, d); if (pg) ef = d[0];
            cyc(2); chk(32'(lamps), {29'h0, 1'b0, ef, 1'b1});
            bus(1'b0, 4'h0, 4'hf, 32'h0); chk(q, {31'h0, ef});
        end
        bus(1'b1, 4'h0, 4'hf, 32'h0); tog = 0;
        repeat (60) begin
            want.disk_activity <= 1'($urandom); pg = lamps.module_active_lamp;
            @(posedge clk_sys); if (lamps.module_active_lamp !== pg) tog++;
        end
        chk(32'(tog > 2), 32'h1);
        want.disk_activity <= 1'b0; cyc(30); chk(32'(lamps), 32'h1);
        want.payload_12v_ok <= 1'b0; cyc(3); chk(32'(lamps), 32'h2);
        want.payload_12v_ok <= 1'b1; want.handle_closed <= 1'b0; want.inserted <= 1'b0;
        per(half(10'h2));
        bus(1'b1, 4'h0, 4'h1, 32'h4); cyc(30); chk(32'(lamps), 32'h5);
        cyc(20); chk(32'(lamps.hot_swap_lamp), 32'h0);
        want.inserted <= 1'b1; want.handle_closed <= 1'b1; cyc(5);
        bus(1'b0, 4'h4, 4'hf, 32'h0); chk(32'(q[2:0]), 32'h2);
        want.handle_closed <= 1'b0; cyc(3); chk(32'(lamps), 32'h5);
        want.mgmt_power_ok <= 1'b0; cyc(3); chk(32'(lamps), 32'h1);
        test_done();
    end
endmodule : tb
